// ### hw/bank_command_timing.sv
// device-side packet framing and core timing for row and column commands
//
// How it works
// - core column path one cycle longer
// - read data after 7 to 13 cycles: programmed 8 to 12, one less or more by delay alternative
// - every packet lasts exactly 4 cycles
// - implied close acts 4 cycles later
// - read delay alternative fixed at init
`timescale 1ns/1ps
module bank_command_timing
	import bank_timing_pkg::*;
#(
	parameter int unsigned BANK_W = 5
) (
	input  wire logic              CLOCK_I,
	input  wire logic              RST_I,
	input  wire logic              ROW_START_I,
	input  wire logic              ROW_OPEN_I,
	input  wire logic [BANK_W-1:0] ROW_BANK_I,
	input  wire logic              COL_START_I,
	input  wire logic [2:0]        COL_OP_I,
	input  wire logic [BANK_W-1:0] COL_BANK_I,
	input  wire logic              EXT_START_I,
	input  wire logic              EXT_CLOSE_I,
	input  wire logic [BANK_W-1:0] EXT_BANK_I,
	input  wire logic [LAT_W-1:0]  READ_LAT_I,
	input  wire logic [1:0]        DELAY_ALT_I,
	output logic                   CORE_OPEN_O,
	output logic      [BANK_W-1:0] CORE_OPEN_BANK_O,
	output logic                   CORE_CLOSE_O,
	output logic      [BANK_W-1:0] CORE_CLOSE_BANK_O,
	output logic                   CORE_COLUMN_O,
	output logic      [BANK_W-1:0] CORE_COLUMN_BANK_O,
	output logic                   READ_DATA_VALID_O,
	output logic      [BANK_W-1:0] READ_BANK_O,
	output logic                   WRITE_CAPTURE_O,
	output logic      [BANK_W-1:0] WRITE_BANK_O,
	output logic                   PACKET_ERROR_O
);

	logic [BEAT_W-1:0] row_beat_q;
	logic [BEAT_W-1:0] col_beat_q;
	logic [BEAT_W-1:0] ext_beat_q;
	logic              row_acc;
	logic              col_acc;
	logic              ext_acc;
	col_op_t           col_op;
	logic              cfg_valid_q;
	logic [LAT_W-1:0]  lat_eff_q;
	logic [LAT_W-1:0]  read_tap;
	logic              wbuf_autoclose_q;
	logic [BANK_W-1:0] wbuf_bank_q;
	logic              col_close;
	logic [BANK_W-1:0] col_close_bank;
	logic              imp_in;
	logic [BANK_W-1:0] imp_in_bank;
	logic              imp_valid;
	logic [BANK_W-1:0] imp_bank;
	logic              col_stage_q;
	logic [BANK_W-1:0] col_stage_bank_q;

	assign col_op = col_op_t'(COL_OP_I);

	// a start inside a running packet is a framing fault and is dropped
	assign row_acc = ROW_START_I && (row_beat_q == BEAT_IDLE);
	assign col_acc = COL_START_I && (col_beat_q == BEAT_IDLE);
	assign ext_acc = EXT_START_I && (ext_beat_q == BEAT_IDLE);

	function automatic logic [BEAT_W-1:0] next_beat(input logic [BEAT_W-1:0] b,
		input logic acc);
		if (acc) begin
			next_beat = BEAT_FIRST;
		end else if (b == BEAT_IDLE || b == BEAT_LAST) begin
			next_beat = BEAT_IDLE;
		end else begin
			next_beat = b + BEAT_FIRST;
		end
	endfunction

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			row_beat_q <= BEAT_IDLE;
			col_beat_q <= BEAT_IDLE;
			ext_beat_q <= BEAT_IDLE;
		end else begin
			row_beat_q <= next_beat(row_beat_q, row_acc);
			col_beat_q <= next_beat(col_beat_q, col_acc);
			ext_beat_q <= next_beat(ext_beat_q, ext_acc);
		end
	end

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			PACKET_ERROR_O <= 1'b0;
		end else begin
			PACKET_ERROR_O <= (ROW_START_I && !row_acc) || (COL_START_I && !col_acc)
				|| (EXT_START_I && !ext_acc);
		end
	end

	// latency is caught once after reset, later changes to the inputs are ignored
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			cfg_valid_q <= 1'b0;
			lat_eff_q   <= LAT_MIN;
		end else if (!cfg_valid_q) begin
			cfg_valid_q <= 1'b1;
			lat_eff_q   <= effective_latency(READ_LAT_I, delay_alt_t'(DELAY_ALT_I));
		end
	end

	assign read_tap = lat_eff_q - READ_TAP_ADJ;

	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			CORE_OPEN_O      <= 1'b0;
			CORE_OPEN_BANK_O <= '0;
		end else begin
			CORE_OPEN_O      <= row_acc && ROW_OPEN_I;
			CORE_OPEN_BANK_O <= ROW_BANK_I;
		end
	end

	// column path takes one stage more than the row path on its way to the core
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			col_stage_q        <= 1'b0;
			col_stage_bank_q   <= '0;
			CORE_COLUMN_O      <= 1'b0;
			CORE_COLUMN_BANK_O <= '0;
		end else begin
			col_stage_q        <= col_acc && (is_read_op(col_op) || is_write_op(col_op));
			col_stage_bank_q   <= COL_BANK_I;
			CORE_COLUMN_O      <= col_stage_q;
			CORE_COLUMN_BANK_O <= col_stage_bank_q;
		end
	end

	// single write buffer; a retire closes the bank only if the write asked for it
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			wbuf_autoclose_q <= 1'b0;
			wbuf_bank_q      <= '0;
		end else if (col_acc && is_write_op(col_op)) begin
			wbuf_autoclose_q <= (col_op == STORE_AUTOCLOSE_CMD);
			wbuf_bank_q      <= COL_BANK_I;
		end else if (col_acc && col_op == COL_RETIRE_CMD) begin
			wbuf_autoclose_q <= 1'b0;
		end
	end

	always_comb begin
		col_close      = 1'b0;
		col_close_bank = COL_BANK_I;
		if (col_acc) begin
			case (col_op)
				FETCH_AUTOCLOSE_CMD: col_close = 1'b1;
				COL_BUS_CLOSE_CMD:   col_close = 1'b1;
				COL_RETIRE_CMD: begin
					col_close      = wbuf_autoclose_q;
					col_close_bank = wbuf_bank_q;
				end
				default: col_close = 1'b0;
			endcase
		end
	end

	// column close wins a tie with an extra-bus close; the controller's spacing avoids it
	assign imp_in      = col_close || (ext_acc && EXT_CLOSE_I);
	assign imp_in_bank = col_close ? col_close_bank : EXT_BANK_I;

	delay_line #(.WIDTH(BANK_W), .DEPTH(PIPE_DEPTH), .TAP_W(LAT_W)) close_pipe (
		.clk_i   (CLOCK_I),
		.rst_i   (RST_I),
		.valid_i (imp_in),
		.data_i  (imp_in_bank),
		.tap_i   (CLOSE_TAP),
		.valid_o (imp_valid),
		.data_o  (imp_bank)
	);

	// a real row close takes priority over an implied one landing in the same cycle
	always_ff @(posedge CLOCK_I) begin
		if (RST_I) begin
			CORE_CLOSE_O      <= 1'b0;
			CORE_CLOSE_BANK_O <= '0;
		end else begin
			CORE_CLOSE_O      <= (row_acc && !ROW_OPEN_I) || imp_valid;
			CORE_CLOSE_BANK_O <= (row_acc && !ROW_OPEN_I) ? ROW_BANK_I : imp_bank;
		end
	end

	delay_line #(.WIDTH(BANK_W), .DEPTH(PIPE_DEPTH), .TAP_W(LAT_W)) read_pipe (
		.clk_i   (CLOCK_I),
		.rst_i   (RST_I),
		.valid_i (col_acc && is_read_op(col_op)),
		.data_i  (COL_BANK_I),
		.tap_i   (read_tap),
		.valid_o (READ_DATA_VALID_O),
		.data_o  (READ_BANK_O)
	);

	// write data is sampled blind at the fixed slot the controller must meet
	delay_line #(.WIDTH(BANK_W), .DEPTH(PIPE_DEPTH), .TAP_W(LAT_W)) write_pipe (
		.clk_i   (CLOCK_I),
		.rst_i   (RST_I),
		.valid_i (col_acc && is_write_op(col_op)),
		.data_i  (COL_BANK_I),
		.tap_i   (WRITE_TAP),
		.valid_o (WRITE_CAPTURE_O),
		.data_o  (WRITE_BANK_O)
	);

	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	sequence s_row_open;
		row_acc && ROW_OPEN_I;
	endsequence

	sequence s_col_access;
		col_acc && (is_read_op(col_op) || is_write_op(col_op));
	endsequence

	sequence s_col_close;
		col_acc && (col_op == COL_BUS_CLOSE_CMD || col_op == FETCH_AUTOCLOSE_CMD);
	endsequence

	chk_row_framing: assert property (row_acc |=> (row_beat_q != BEAT_IDLE) [*3] ##1
		(row_beat_q == BEAT_IDLE))
		else $error("row packet not four cycles long");
	chk_col_framing: assert property (col_acc |=> (col_beat_q != BEAT_IDLE) [*3] ##1
		(col_beat_q == BEAT_IDLE || col_acc))
		else $error("column packet not four cycles long");
	chk_open_timing: assert property (s_row_open |-> ##1 CORE_OPEN_O
		##0 (CORE_OPEN_BANK_O == $past(ROW_BANK_I)))
		else $error("core open not one cycle after row packet");
	chk_column_extra: assert property (s_col_access |-> ##1 !CORE_COLUMN_O ##1 CORE_COLUMN_O)
		else $error("core column strobe not one cycle later than row path");
	chk_implied_close: assert property (s_col_close |-> ##5 CORE_CLOSE_O
		##0 (CORE_CLOSE_BANK_O == $past(COL_BANK_I, 5)))
		else $error("implied close not seen as row close four cycles on");
	chk_read_window: assert property (col_acc && is_read_op(col_op) |-> ##[7:13]
		READ_DATA_VALID_O)
		else $error("read data outside programmed latency window");
	chk_latency_range: assert property (cfg_valid_q |-> lat_eff_q >= LAT_MIN - LAT_STEP
		&& lat_eff_q <= LAT_MAX + LAT_STEP)
		else $error("effective read latency out of range");
	chk_latency_fixed: assert property (cfg_valid_q && $past(cfg_valid_q) |->
		$stable(lat_eff_q))
		else $error("read latency changed after initialisation");
	chk_write_slot: assert property (col_acc && is_write_op(col_op) |-> ##6 WRITE_CAPTURE_O)
		else $error("write capture not six cycles after write packet");

endmodule

// ### inc/bank_timing_pkg.sv
// constants, command codes and helpers for the bank command timing block
package bank_timing_pkg;

	localparam int unsigned LAT_W                 = 4;
	localparam int unsigned BEAT_W                = 2;
	localparam int unsigned PACKET_LENGTH         = 4;
	localparam int unsigned IMPLIED_CLOSE_OFFSET  = 4;
	localparam int unsigned WRITE_DATA_LATENCY    = 6;
	localparam int unsigned READ_DATA_LATENCY_MIN = 8;
	localparam int unsigned READ_DATA_LATENCY_MAX = 12;
	localparam int unsigned ROW_CORE_DELAY        = 1;
	localparam int unsigned COLUMN_PATH_EXTRA     = 1;
	localparam int unsigned PIPE_OVERHEAD         = 2;
	localparam int unsigned MERGE_STAGE           = 1;
	localparam int unsigned PIPE_DEPTH            = 12;

	localparam logic [BEAT_W-1:0] BEAT_IDLE  = 2'h0;
	localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h1;
	localparam logic [BEAT_W-1:0] BEAT_LAST  = BEAT_W'(PACKET_LENGTH - 1);

	localparam logic [LAT_W-1:0] LAT_MIN  = LAT_W'(READ_DATA_LATENCY_MIN);
	localparam logic [LAT_W-1:0] LAT_MAX  = LAT_W'(READ_DATA_LATENCY_MAX);
	localparam logic [LAT_W-1:0] LAT_STEP = 4'h1;

	localparam logic [LAT_W-1:0] CLOSE_TAP =
		LAT_W'(IMPLIED_CLOSE_OFFSET + ROW_CORE_DELAY - PIPE_OVERHEAD - MERGE_STAGE);
	localparam logic [LAT_W-1:0] WRITE_TAP = LAT_W'(WRITE_DATA_LATENCY - PIPE_OVERHEAD);
	localparam logic [LAT_W-1:0] READ_TAP_ADJ = LAT_W'(PIPE_OVERHEAD);

	typedef enum logic [2:0] {
		COL_NOP_CMD         = 3'h0,
		COL_READ_CMD        = 3'h1,
		COL_WRITE_CMD       = 3'h2,
		FETCH_AUTOCLOSE_CMD = 3'h3,
		STORE_AUTOCLOSE_CMD = 3'h4,
		COL_RETIRE_CMD      = 3'h5,
		COL_BUS_CLOSE_CMD   = 3'h7
	} col_op_t;

	typedef enum logic [1:0] {
		ALT_NOMINAL = 2'h0,
		ALT_EARLY   = 2'h1,
		ALT_LATE    = 2'h2
	} delay_alt_t;

	function automatic logic is_read_op(input col_op_t op);
		return (op == COL_READ_CMD) || (op == FETCH_AUTOCLOSE_CMD);
	endfunction

	function automatic logic is_write_op(input col_op_t op);
		return (op == COL_WRITE_CMD) || (op == STORE_AUTOCLOSE_CMD);
	endfunction

	// out-of-range programming is pulled to the nearest legal latency
	function automatic logic [LAT_W-1:0] effective_latency(input logic [LAT_W-1:0] lat,
		input delay_alt_t alt);
		logic [LAT_W-1:0] c;
		c = (lat < LAT_MIN) ? LAT_MIN : ((lat > LAT_MAX) ? LAT_MAX : lat);
		case (alt)
			ALT_EARLY: effective_latency = c - LAT_STEP;
			ALT_LATE:  effective_latency = c + LAT_STEP;
			default:   effective_latency = c;
		endcase
	endfunction

endpackage

// ### hw/delay_line.sv
// tapped delay line with registered output, used for the fixed latencies
`timescale 1ns/1ps
module delay_line #(
	parameter int unsigned WIDTH = 1,
	parameter int unsigned DEPTH = 12,
	parameter int unsigned TAP_W = 4
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             valid_i,
	input  wire logic [WIDTH-1:0] data_i,
	input  wire logic [TAP_W-1:0] tap_i,
	output logic                  valid_o,
	output logic      [WIDTH-1:0] data_o
);

	logic [DEPTH-1:0] vld_q;
	logic [WIDTH-1:0] dat_q [DEPTH];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vld_q <= '0;
		end else begin
			vld_q <= {vld_q[DEPTH-2:0], valid_i};
		end
	end

	// data needs no reset, the valid bits qualify it
	always_ff @(posedge clk_i) begin
		dat_q[0] <= data_i;
		for (int i = 1; i < DEPTH; i++) begin
			dat_q[i] <= dat_q[i-1];
		end
	end

	// an entry leaves tap_i + 2 cycles after it enters
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			data_o  <= '0;
		end else begin
			valid_o <= vld_q[tap_i];
			data_o  <= dat_q[tap_i];
		end
	end

endmodule

// ### tb/packet_source.sv
// controller-side model: spaces row, column and extra packets
`timescale 1ns/1ps
module packet_source #(
	parameter bit FAST = 1'b1
) (
	input  wire logic       clk_i,
	output logic            row_start_o,
	output logic            row_open_o,
	output logic      [4:0] row_bank_o,
	output logic            col_start_o,
	output logic      [2:0] col_op_o,
	output logic      [4:0] col_bank_o,
	output logic            ext_start_o,
	output logic            ext_close_o,
	output logic      [4:0] ext_bank_o,
	output int              now_o
);
	int         now_q = 0;
	int         bus_t[3] = '{default: -100};
	int         opn[32] = '{default: -100};
	int         cls[32] = '{default: -100};
	int         rdt[32] = '{default: -100};
	int         any_open = -100;
	int         any_close = -100;
	int         wr_t = -100;
	logic [4:0] wr_b = 5'h00;
	bit         wr_ac = 1'b0;
	assign now_o = now_q;
	always @(posedge clk_i) now_q <= now_q + 1;
	initial begin
		row_start_o = 1'b0;
		row_open_o = 1'b0;
		row_bank_o = 5'h00;
		col_start_o = 1'b0;
		col_op_o = 3'h0;
		col_bank_o = 5'h00;
		ext_start_o = 1'b0;
		ext_close_o = 1'b0;
		ext_bank_o = 5'h00;
	end
	function automatic int mx(input int a, input int b);
		return (a > b) ? a : b;
	endfunction
	// rude skips the same-bus packet spacing limit, only used with a column nop
	task automatic send(input int bus, input int op, input logic [4:0] b, input bit rude,
		output int t0);
		int         e;
		int         off;
		bit         cl;
		logic [4:0] bb;
		bb = (bus == 1 && op == 5) ? wr_b : b;
		cl = (bus == 0) ? (op == 0) : ((bus == 2) ? (op != 0)
			: (op == 3 || op == 7 || (op == 5 && wr_ac)));
		off = (bus == 0) ? 0 : 4;
		e = rude ? 0 : bus_t[bus] + 4;
		if (bus == 0 && op == 1)
			e = mx(e, mx(any_open + 8, mx(opn[b] + 28, cls[b] + 8)));
		if (bus == 1 && op >= 1 && op <= 4)
			e = mx(e, opn[b] + (FAST ? 9 : 7));
		if (bus == 1 && op == 5)
			e = mx(e, wr_t + 8);
		if (cl)
			e = mx(e, mx(any_close + 8, mx(opn[bb] + 20, rdt[bb] + 4)) - off);
		@(posedge clk_i);
		while (now_q + 1 < e)
			@(posedge clk_i);
		case (bus)
			0: begin
				row_start_o <= 1'b1;
				row_open_o <= op[0];
				row_bank_o <= b;
			end
			1: begin
				col_start_o <= 1'b1;
				col_op_o <= 3'(op);
				col_bank_o <= b;
			end
			default: begin
				ext_start_o <= 1'b1;
				ext_close_o <= (op != 0);
				ext_bank_o <= b;
			end
		endcase
		@(posedge clk_i);
		t0 = now_q;
		row_start_o <= 1'b0;
		col_start_o <= 1'b0;
		ext_start_o <= 1'b0;
		// idle bank fields flip so a stale value is never mistaken for a held one
		row_bank_o <= ~row_bank_o;
		col_bank_o <= ~col_bank_o;
		ext_bank_o <= ~ext_bank_o;
		bus_t[bus] = t0;
		if (bus == 0 && op == 1) begin
			opn[b] = t0;
			any_open = t0;
		end
		if (cl) begin
			cls[bb] = t0 + off;
			any_close = cls[bb];
		end
		if (bus == 1 && (op == 1 || op == 3 || op == 5))
			rdt[bb] = t0;
		if (bus == 1 && (op == 2 || op == 4)) begin
			wr_t = t0;
			wr_b = b;
			wr_ac = (op == 4);
		end
	endtask
endmodule

// ### tb/tb.sv
// bench: packets from the controller model, core strobes timed per packet
`timescale 1ns/1ps
module tb;
	import bank_timing_pkg::*;
	logic       CLOCK_I, RST_I, rs, ro, cs, es, ec, c_op, c_cl, c_co, rdv, wcap, perr;
	logic [4:0] rb, cb, eb, ob, clb, cob, rdb, wb;
	logic [2:0] co;
	logic [3:0] lat;
	logic [1:0] alt;
	int         now, n_errors, samples_checked, t0, t_ev[6], n_ev[6];
	logic [4:0] b_ev[6];
	string      nm[6] = '{"open", "close", "column", "read", "write", "error"};
	packet_source #(.FAST(1'b1)) src (.clk_i(CLOCK_I), .row_start_o(rs), .row_open_o(ro),
		.row_bank_o(rb), .col_start_o(cs), .col_op_o(co), .col_bank_o(cb), .ext_start_o(es),
		.ext_close_o(ec), .ext_bank_o(eb), .now_o(now));
	bank_command_timing #(.BANK_W(5)) DUT (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .ROW_START_I(rs),
		.ROW_OPEN_I(ro), .ROW_BANK_I(rb), .COL_START_I(cs), .COL_OP_I(co), .COL_BANK_I(cb),
		.EXT_START_I(es), .EXT_CLOSE_I(ec), .EXT_BANK_I(eb), .READ_LAT_I(lat),
		.DELAY_ALT_I(alt), .CORE_OPEN_O(c_op), .CORE_OPEN_BANK_O(ob), .CORE_CLOSE_O(c_cl),
		.CORE_CLOSE_BANK_O(clb), .CORE_COLUMN_O(c_co), .CORE_COLUMN_BANK_O(cob),
		.READ_DATA_VALID_O(rdv), .READ_BANK_O(rdb), .WRITE_CAPTURE_O(wcap),
		.WRITE_BANK_O(wb), .PACKET_ERROR_O(perr));
	initial begin
		CLOCK_I = 1'b0;
		forever #2.5 CLOCK_I = ~CLOCK_I;
	end
	function automatic void note(input int k, input logic [4:0] b);
		t_ev[k] = now;
		b_ev[k] = b;
		n_ev[k]++;
	endfunction
	// sampled 1 ns after the edge so the registered strobes have settled
	always @(posedge CLOCK_I) begin
		#1;
		if (c_op === 1'b1) note(0, ob);
		if (c_cl === 1'b1) note(1, clb);
		if (c_co === 1'b1) note(2, cob);
		if (rdv === 1'b1) note(3, rdb);
		if (wcap === 1'b1) note(4, wb);
		if (perr === 1'b1) note(5, 5'h00);
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (n_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic do_reset(input logic [3:0] l, input logic [1:0] a);
		@(posedge CLOCK_I);
		RST_I <= 1'b1;
		lat <= l;
		alt <= a;
		repeat (8) @(posedge CLOCK_I);
		RST_I <= 1'b0;
		repeat (2) @(posedge CLOCK_I);
		n_ev = '{default: 0};
	endtask
	task automatic go(input int bus, input int op, input logic [4:0] b, input bit rude);
		src.send(bus, op, b, rude, t0);
	endtask
	// one pulse of strobe k, d cycles after the last packet start
	task automatic exp_ev(input int k, input int d, input logic [4:0] b);
		int i;
		for (i = 0; i < 64 && now < t0 + d + 3; i++)
			@(posedge CLOCK_I);
		if (i == 64) begin
			n_errors++;
			stop_test();
		end else begin
			check(nm[k], t_ev[k] - t0, d);
			check(nm[k], 32'(b_ev[k]), 32'(b));
			check(nm[k], n_ev[k], 1);
			n_ev[k] = 0;
		end
	endtask
	task automatic s_row();
		go(0, 1, 5'h03, 1'b0);
		exp_ev(0, 1, 5'h03);
		go(0, 1, 5'h09, 1'b0);
		exp_ev(0, 1, 5'h09);
		go(0, 0, 5'h03, 1'b0);
		exp_ev(1, 1, 5'h03);
		go(0, 0, 5'h09, 1'b0);
		exp_ev(1, 1, 5'h09);
	endtask
	task automatic s_write();
		go(0, 1, 5'h04, 1'b0);
		exp_ev(0, 1, 5'h04);
		go(1, 2, 5'h04, 1'b0);
		exp_ev(2, 2, 5'h04);
		exp_ev(4, 6, 5'h04);
		go(1, 5, 5'h00, 1'b0);
		go(1, 4, 5'h04, 1'b0);
		exp_ev(4, 6, 5'h04);
		check("close", n_ev[1], 0);
		go(1, 5, 5'h00, 1'b0);
		exp_ev(1, 5, 5'h04);
	endtask
	task automatic s_read();
		int lv[6] = '{8, 12, 15, 8, 12, 3};
		int av[6] = '{0, 0, 0, 1, 2, 0};
		int ev[6] = '{8, 12, 12, 7, 13, 8};
		for (int i = 0; i < 6; i++) begin
			do_reset(4'(lv[i]), 2'(av[i]));
			go(0, 1, 5'(i + 1), 1'b0);
			exp_ev(0, 1, 5'(i + 1));
			go(1, 3, 5'(i + 1), 1'b0);
			exp_ev(2, 2, 5'(i + 1));
			exp_ev(3, ev[i], 5'(i + 1));
			exp_ev(1, 5, 5'(i + 1));
		end
	endtask
	task automatic s_close();
		go(0, 1, 5'h06, 1'b0);
		go(1, 1, 5'h06, 1'b0);
		exp_ev(3, 8, 5'h06);
		go(1, 7, 5'h06, 1'b0);
		exp_ev(1, 5, 5'h06);
		go(0, 1, 5'h07, 1'b0);
		go(2, 1, 5'h07, 1'b0);
		exp_ev(1, 5, 5'h07);
	endtask
	task automatic s_err();
		n_ev = '{default: 0};
		go(2, 0, 5'h02, 1'b0);
		go(1, 0, 5'h00, 1'b0);
		go(1, 6, 5'h01, 1'b0);
		go(1, 0, 5'h00, 1'b0);
		go(1, 0, 5'h00, 1'b1);
		exp_ev(5, 1, 5'h00);
		check("column", n_ev[2] + n_ev[1], 0);
	endtask
	initial begin
		RST_I = 1'b1;
		lat = 4'h8;
		alt = 2'h0;
		do_reset(4'h8, 2'h0);
		s_row();
		s_write();
		s_read();
		s_close();
		s_err();
		stop_test();
	end
endmodule
